// ==== uart_fifo_pkg.sv ====
// constants shared by the serial queue control block and its helpers
package uart_fifo_pkg;

   // ****************************************************************
   // register byte addresses
   // ****************************************************************
   localparam logic [31:0] ADDR_QUEUE_DATA = 32'h4000_8000; // rx read pops, tx write pushes
   localparam logic [31:0] ADDR_QUEUE_CONTROL = 32'h4000_8008; // write-only control
   localparam logic [31:0] ADDR_QUEUE_STATUS = 32'h4000_8020; // fill levels and settings
   localparam logic [31:0] ADDR_IRQ_STATUS = 32'h4000_8024; // sticky events, write one to clear
   localparam logic [31:0] ADDR_IRQ_MASK = 32'h4000_8028; // event enables
   localparam logic [31:0] ADDR_CHAR_TIME = 32'h4000_802C; // clock cycles per character

   // ****************************************************************
   // control register fields
   // ****************************************************************
   localparam int CTRL_EN_BIT = 0; // queue_enable
   localparam int CTRL_RX_FLUSH_BIT = 1; // rx_queue_flush, self-clearing
   localparam int CTRL_TX_FLUSH_BIT = 2; // tx_queue_flush, self-clearing
   localparam int CTRL_THR_LSB = 6; // rx_fill_threshold low bit
   localparam int CTRL_THR_MSB = 7; // rx_fill_threshold high bit
   localparam int THR_W = 2; // threshold code width
   localparam logic [THR_W-1:0] THR_RESET = 2'h0; // threshold code after reset

   // ****************************************************************
   // threshold codes and their character counts
   // ****************************************************************
   localparam logic [THR_W-1:0] THR_CODE_0 = 2'h0;
   localparam logic [THR_W-1:0] THR_CODE_1 = 2'h1;
   localparam logic [THR_W-1:0] THR_CODE_2 = 2'h2;
   localparam logic [THR_W-1:0] THR_CODE_3 = 2'h3;
   localparam int CNT_W = 5; // width of a fill count for a 16-entry queue
   localparam logic [CNT_W-1:0] THR_CHARS_0 = 5'h01;
   localparam logic [CNT_W-1:0] THR_CHARS_1 = 5'h04;
   localparam logic [CNT_W-1:0] THR_CHARS_2 = 5'h08;
   localparam logic [CNT_W-1:0] THR_CHARS_3 = 5'h0E;

   // ****************************************************************
   // status word layout
   // ****************************************************************
   localparam int STAT_RX_CNT_LSB = 0; // rx fill count
   localparam int STAT_TX_CNT_LSB = 8; // tx fill count
   localparam int STAT_EN_BIT = 16; // queue_enable as stored
   localparam int STAT_THR_LSB = 17; // threshold code as stored

   // ****************************************************************
   // interrupt status and mask bits
   // ****************************************************************
   localparam int IRQ_W = 3;
   localparam int IRQ_THRESH_BIT = 0; // rx fill reached threshold
   localparam int IRQ_TIMEOUT_BIT = 1; // rx idle timeout
   localparam int IRQ_OVERFLOW_BIT = 2; // rx character dropped on full queue
   localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

   // ****************************************************************
   // sizes and timing
   // ****************************************************************
   localparam int QUEUE_DEPTH = 16; // entries per queue
   localparam int CHAR_W = 8; // bits per character entry
   localparam int CHAR_TIME_W = 16; // width of the character time register
   localparam logic [CHAR_TIME_W-1:0] CHAR_TIME_RESET = 16'h01B2; // about 115200 baud at 50 MHz
   localparam int IDLE_CHAR_TIMES = 4; // idle span, inside the 3.5 to 4.5 window

   // maps a threshold code to its character count
   function automatic logic [CNT_W-1:0] thr_chars(input logic [THR_W-1:0] code);
      logic [CNT_W-1:0] r;
      unique case (code)
         THR_CODE_0: r = THR_CHARS_0;
         THR_CODE_1: r = THR_CHARS_1;
         THR_CODE_2: r = THR_CHARS_2;
         THR_CODE_3: r = THR_CHARS_3;
      endcase
      return r;
   endfunction

endpackage

// ==== char_queue.sv ====
// circular character queue with flush, fill count and full/empty flags
`timescale 1ns/1ps
module char_queue
   import uart_fifo_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic flush,
   input wire logic push,
   input wire logic [WIDTH-1:0] push_data,
   input wire logic pop,
   output logic [WIDTH-1:0] head_data,
   output logic [$clog2(DEPTH):0] count,
   output logic full,
   output logic empty
);
   localparam int AW = $clog2(DEPTH);

   // depth must be a power of two so the pointers wrap by themselves
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("char_queue depth must be a power of two");
   end

   logic [WIDTH-1:0] mem_q [DEPTH]; // character storage
   logic [AW-1:0] wr_ptr_q; // next slot to fill
   logic [AW-1:0] rd_ptr_q; // oldest entry
   logic [AW:0] count_q; // entries held
   logic do_push; // accepted push
   logic do_pop; // accepted pop

   // a push on a full queue and a pop on an empty one are dropped
   assign do_push = push && !full;
   assign do_pop = pop && !empty;
   assign full = (count_q == (AW + 1)'(DEPTH));
   assign empty = (count_q == '0);
   assign count = count_q;
   assign head_data = mem_q[rd_ptr_q];

   // pointers and count; flush discards every entry at once
   always_ff @(posedge ref_clk) begin
      if (!nrst || flush) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         if (do_push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         count_q <= count_q + (AW + 1)'(do_push) - (AW + 1)'(do_pop);
      end
   end

   // storage has no reset; stale entries are never visible as valid
   always_ff @(posedge ref_clk) begin
      if (do_push) begin
         mem_q[wr_ptr_q] <= push_data;
      end
   end

   depth_bound_a: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE13
      (push && full && !pop && !flush) |=> (count_q == (AW + 1)'(DEPTH)))
      else $error("queue count moved past its depth");

endmodule

// ==== idle_timer.sv ====
// counts idle clock cycles of the receive queue and flags the timeout
`timescale 1ns/1ps
module idle_timer
   import uart_fifo_pkg::*;
#(
   parameter int CW = 16
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic armed,
   input wire logic activity,
   input wire logic [CW-1:0] char_cycles,
   output logic expired
);
   if (CW < 1) begin : g_bad_width
      $error("idle_timer needs a counter at least one bit wide");
   end

   logic [CW+1:0] limit_w; // idle span in cycles
   logic [CW+1:0] cnt_q; // idle cycles seen so far
   logic expired_q; // timeout flag

   assign limit_w = (CW + 2)'(char_cycles) * (CW + 2)'(IDLE_CHAR_TIMES);
   assign expired = expired_q;

   // restart on any queue activity; hold the flag until activity or disarm
   always_ff @(posedge ref_clk) begin
      if (!nrst || !armed || activity) begin
         cnt_q <= '0;
         expired_q <= 1'b0;
      end else if (cnt_q >= limit_w) begin
         expired_q <= 1'b1; // RULE12
      end else begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

endmodule

// ==== uart_fifo_control.sv ====
// receive and transmit queue control with its register port and interrupts
//
// Functional notes
// RULE1: enable set admits writes to bits 7:1
// RULE2: software keeps the queue enable set
// RULE3: enable change empties both queues
// RULE4: rx flush bit empties rx queue
// RULE5: tx flush bit empties tx queue
// RULE6: zero flush bits leave queues alone
// RULE7: threshold codes give 1, 4, 8, 14
// RULE8: receive interrupt once fill reaches threshold
// RULE9: control write-only, fields reset to zero
// RULE10: software writes zeros to bits 5:4
// RULE11: threshold interrupt drops below threshold
// RULE12: idle timeout when rx holds data
// RULE13: each queue holds sixteen entries
`timescale 1ns/1ps
module uart_fifo_control
   import uart_fifo_pkg::*;
#(
   parameter int DEPTH = QUEUE_DEPTH
) (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [31:0] bus_addr,
   input wire logic [31:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [31:0] bus_rdata,
   input wire logic rx_push,
   input wire logic [CHAR_W-1:0] rx_push_data,
   output logic rx_full,
   input wire logic tx_pop,
   output logic [CHAR_W-1:0] tx_data,
   output logic tx_avail,
   output logic queue_enable,
   output logic rx_threshold_irq,
   output logic rx_idle_timeout_irq,
   output logic irq
);
   // the threshold of fourteen and the fixed count width need sixteen entries
   if (DEPTH != QUEUE_DEPTH) begin : g_bad_depth
      $error("uart_fifo_control supports only the sixteen-entry depth");
   end

   // ****************************************************************
   // state
   // ****************************************************************
   logic enable_q; // stored queue_enable
   logic [THR_W-1:0] thr_q; // stored rx_fill_threshold code
   logic [IRQ_W-1:0] irq_status_q; // sticky events
   logic [IRQ_W-1:0] irq_status_d; // next sticky events
   logic [IRQ_W-1:0] irq_mask_q; // event enables
   logic [CHAR_TIME_W-1:0] char_time_q; // cycles per character
   logic [31:0] bus_rdata_q; // read answer
   logic rx_full_q; // registered rx full
   logic [CHAR_W-1:0] tx_data_q; // registered tx head
   logic tx_avail_q; // registered tx not empty, forced low in the cycle after a pop
   logic thr_irq_q; // rx_threshold_irq level
   logic idle_irq_q; // rx_idle_timeout_irq level
   logic irq_q; // combined interrupt

   // ****************************************************************
   // address decode
   // ****************************************************************
   logic wr_ctrl; // write to queue_control
   logic wr_data; // write to the data port
   logic rd_data; // read of the data port
   logic wr_irq_status; // clear of sticky events
   logic wr_irq_mask; // mask update
   logic wr_char_time; // character time update
   assign wr_ctrl = bus_wr && (bus_addr == ADDR_QUEUE_CONTROL);
   assign wr_data = bus_wr && (bus_addr == ADDR_QUEUE_DATA);
   assign rd_data = bus_rd && (bus_addr == ADDR_QUEUE_DATA);
   assign wr_irq_status = bus_wr && (bus_addr == ADDR_IRQ_STATUS);
   assign wr_irq_mask = bus_wr && (bus_addr == ADDR_IRQ_MASK);
   assign wr_char_time = bus_wr && (bus_addr == ADDR_CHAR_TIME);

   // ****************************************************************
   // control write decode
   // ****************************************************************
   logic new_en; // enable bit of this write
   logic en_change; // this write flips the enable
   logic fields_ok; // bits 7:1 of this write are taken
   logic rx_flush; // empty the rx queue this cycle
   logic tx_flush; // empty the tx queue this cycle
   assign new_en = bus_wdata[CTRL_EN_BIT];
   // any flip of the enable, either way, empties both queues
   assign en_change = wr_ctrl && (new_en != enable_q); // RULE3
   // upper fields only count when the same write keeps the queues enabled
   assign fields_ok = wr_ctrl && new_en; // RULE1
   // flush bits act as pulses; a zero leaves its queue alone
   assign rx_flush = en_change || (fields_ok && bus_wdata[CTRL_RX_FLUSH_BIT]); // RULE4 RULE6
   assign tx_flush = en_change || (fields_ok && bus_wdata[CTRL_TX_FLUSH_BIT]); // RULE5 RULE6

   // ****************************************************************
   // queue traffic
   // ****************************************************************
   logic rx_push_ok; // receiver push while enabled
   logic rx_pop_ok; // software read while enabled
   logic tx_push_ok; // software write while enabled
   logic tx_pop_ok; // transmitter pop while enabled
   logic rx_overflow; // receiver push lost on a full queue
   // queues only run while enabled; the enable must stay set for service
   assign rx_push_ok = rx_push && enable_q; // RULE1 RULE2
   assign rx_pop_ok = rd_data && enable_q;
   assign tx_push_ok = wr_data && enable_q;
   assign tx_pop_ok = tx_pop && enable_q;

   logic [CHAR_W-1:0] rx_head; // oldest rx character
   logic [CNT_W-1:0] rx_count; // rx fill
   logic rx_full_w; // rx queue full
   logic rx_empty; // rx queue empty
   logic [CHAR_W-1:0] tx_head; // oldest tx character
   logic [CNT_W-1:0] tx_count; // tx fill
   logic tx_empty; // tx queue empty
   assign rx_overflow = rx_push_ok && rx_full_w;

   // receive queue, filled by the receiver and drained by software
   char_queue #(
      .WIDTH(CHAR_W),
      .DEPTH(DEPTH)
   ) u_rx_queue (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .flush(rx_flush),
      .push(rx_push_ok),
      .push_data(rx_push_data),
      .pop(rx_pop_ok),
      .head_data(rx_head),
      .count(rx_count),
      .full(rx_full_w),
      .empty(rx_empty)
   ); // RULE13

   // transmit queue, filled by software and drained by the transmitter
   char_queue #(
      .WIDTH(CHAR_W),
      .DEPTH(DEPTH)
   ) u_tx_queue (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .flush(tx_flush),
      .push(tx_push_ok),
      .push_data(bus_wdata[CHAR_W-1:0]),
      .pop(tx_pop_ok),
      .head_data(tx_head),
      .count(tx_count),
      .full(),
      .empty(tx_empty)
   ); // RULE13

   // ****************************************************************
   // receive threshold and idle timeout
   // ****************************************************************
   logic [CNT_W-1:0] threshold_chars; // selected fill threshold
   logic thr_reached; // fill at or above threshold
   logic idle_expired; // idle span elapsed with data held
   assign threshold_chars = thr_chars(thr_q); // RULE7
   // level follows the fill both up and down
   assign thr_reached = enable_q && (rx_count >= threshold_chars); // RULE8 RULE11

   // idle timer, armed while rx holds data, restarted by any rx activity
   idle_timer #(
      .CW(CHAR_TIME_W)
   ) u_idle_timer (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .armed(enable_q && !rx_empty),
      .activity(rx_push_ok || rx_pop_ok || rx_flush),
      .char_cycles(char_time_q),
      .expired(idle_expired)
   ); // RULE12

   // ****************************************************************
   // interrupt status
   // ****************************************************************
   logic [IRQ_W-1:0] irq_events; // events seen this cycle
   logic [IRQ_W-1:0] irq_clear; // bits software clears this cycle
   assign irq_events = {rx_overflow, idle_expired, thr_reached};
   assign irq_clear = wr_irq_status ? bus_wdata[IRQ_W-1:0] : '0;
   // a new event wins over a clear in the same cycle
   assign irq_status_d = (irq_status_q & ~irq_clear) | irq_events;

   // ****************************************************************
   // read mux
   // ****************************************************************
   logic [31:0] status_word; // fill levels and settings
   logic [31:0] read_word; // word for the addressed register
   assign status_word = (32'(rx_count) << STAT_RX_CNT_LSB) | (32'(tx_count) << STAT_TX_CNT_LSB) |
                        (32'(enable_q) << STAT_EN_BIT) | (32'(thr_q) << STAT_THR_LSB);
   // control is write-only and reads as zero, as do unmapped addresses
   assign read_word = (bus_addr == ADDR_QUEUE_DATA && !rx_empty && enable_q) ? 32'(rx_head) :
                      (bus_addr == ADDR_QUEUE_STATUS) ? status_word :
                      (bus_addr == ADDR_IRQ_STATUS) ? 32'(irq_status_q) :
                      (bus_addr == ADDR_IRQ_MASK) ? 32'(irq_mask_q) :
                      (bus_addr == ADDR_CHAR_TIME) ? 32'(char_time_q) : 32'h0000_0000; // RULE9

   // ****************************************************************
   // control register
   // ****************************************************************
   // enable and threshold reset to zero; flush bits are never stored
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         enable_q <= 1'b0; // RULE9
         thr_q <= THR_RESET; // RULE9
      end else if (wr_ctrl) begin
         enable_q <= new_en;
         if (fields_ok) begin
            thr_q <= bus_wdata[CTRL_THR_MSB:CTRL_THR_LSB]; // RULE1 RULE7
         end
      end
   end

   // mask, character time and sticky status
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         irq_mask_q <= IRQ_RESET;
         irq_status_q <= IRQ_RESET;
         char_time_q <= CHAR_TIME_RESET;
      end else begin
         irq_status_q <= irq_status_d;
         if (wr_irq_mask) begin
            irq_mask_q <= bus_wdata[IRQ_W-1:0];
         end
         if (wr_char_time) begin
            char_time_q <= bus_wdata[CHAR_TIME_W-1:0];
         end
      end
   end

   // read answer stands only in the cycle after the read strobe
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         bus_rdata_q <= 32'h0000_0000;
      end else begin
         bus_rdata_q <= bus_rd ? read_word : 32'h0000_0000;
      end
   end

   // registered outputs toward the serial engine and the interrupt line
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         rx_full_q <= 1'b0;
         tx_data_q <= '0;
         tx_avail_q <= 1'b0;
         thr_irq_q <= 1'b0;
         idle_irq_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         rx_full_q <= rx_full_w;
         tx_data_q <= tx_head;
         tx_avail_q <= enable_q && !tx_empty && !tx_pop_ok;
         thr_irq_q <= thr_reached; // RULE8 RULE11
         idle_irq_q <= idle_expired; // RULE12
         irq_q <= |(irq_status_d & irq_mask_q);
      end
   end

   assign bus_rdata = bus_rdata_q;
   assign rx_full = rx_full_q;
   assign tx_data = tx_data_q;
   assign tx_avail = tx_avail_q;
   assign queue_enable = enable_q;
   assign rx_threshold_irq = thr_irq_q;
   assign rx_idle_timeout_irq = idle_irq_q;
   assign irq = irq_q;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   field_gate_a: assert property ( // RULE1
      (wr_ctrl && !bus_wdata[CTRL_EN_BIT]) |=> (thr_q == $past(thr_q)))
      else $error("threshold changed by a write with enable clear");

   enable_flush_a: assert property ( // RULE3
      en_change |=> (rx_count == '0 && tx_count == '0))
      else $error("enable change did not empty the queues");

   rx_flush_a: assert property ( // RULE4
      (fields_ok && bus_wdata[CTRL_RX_FLUSH_BIT]) |=> (rx_count == '0) ##1 (rx_count <= 5'h01))
      else $error("rx flush left characters behind");

   tx_flush_a: assert property ( // RULE5
      (fields_ok && bus_wdata[CTRL_TX_FLUSH_BIT]) |=> (tx_count == '0) ##1 (tx_count <= 5'h01))
      else $error("tx flush left characters behind");

   no_flush_a: assert property ( // RULE6
      (fields_ok && enable_q && !bus_wdata[CTRL_RX_FLUSH_BIT] && !rx_pop_ok)
      |=> (rx_count >= $past(rx_count)))
      else $error("rx queue lost characters on a zero flush bit");

   thr_map_a: assert property ( // RULE7
      (fields_ok && bus_wdata[CTRL_THR_MSB:CTRL_THR_LSB] == THR_CODE_3) |=> (threshold_chars == THR_CHARS_3))
      else $error("top threshold code does not select fourteen");

   thr_irq_a: assert property ( // RULE8
      (enable_q && rx_count >= threshold_chars) |=> rx_threshold_irq)
      else $error("threshold reached without receive interrupt");

   thr_drop_a: assert property ( // RULE11
      (rx_count < threshold_chars) |=> !rx_threshold_irq)
      else $error("receive interrupt held below threshold");

   ctrl_reset_a: assert property (@(posedge ref_clk) disable iff (1'b0) // RULE9
      !nrst |=> (!enable_q && thr_q == THR_RESET && bus_rdata == 32'h0000_0000))
      else $error("control fields not zero after reset");

   idle_data_a: assert property ( // RULE12
      $rose(rx_idle_timeout_irq) |-> ($past(rx_count) != '0))
      else $error("idle timeout raised with an empty receive queue");

endmodule

// ==== line_side_model.sv ====
// line-side partner: feeds received characters and drains the transmit queue
`timescale 1ns/1ps
module line_side_model (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic push_req,
   input wire logic [7:0] push_byte,
   input wire logic stall,
   input wire logic tx_avail,
   input wire logic [7:0] tx_data,
   output logic rx_push,
   output logic [7:0] rx_push_data,
   output logic tx_pop,
   output logic [7:0] last_tx,
   output logic [7:0] tx_got
);
   // ****************************************************************
   // receiver forwards one character per request, transmitter drains
   // ****************************************************************
   // idle data line toggles so a stale byte is never mistaken for a fresh one
   // a pop is never issued in the cycle after a pop, since tx_avail lags it
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         rx_push <= 1'b0;
         rx_push_data <= 8'h00;
         tx_pop <= 1'b0;
         last_tx <= 8'h00;
         tx_got <= 8'h00;
      end else begin
         rx_push <= push_req;
         rx_push_data <= push_req ? push_byte : ~rx_push_data;
         tx_pop <= tx_avail && !tx_pop && !stall;
         if (tx_pop && tx_avail) begin
            last_tx <= tx_data;
            tx_got <= tx_got + 8'h01;
         end
      end
   end
endmodule

// ==== uart_fifo_control_test.sv ====
// self-checking bench for the serial queue control block
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin num_errors++; $display("unexpected %s exp %0h got %0h", nm, ex, gt); end end
module uart_fifo_control_test
   import uart_fifo_pkg::*;
;
   logic ref_clk = 1'b0, nrst = 1'b0, bus_wr = 1'b0, bus_rd = 1'b0, push_req = 1'b0, stall = 1'b0;
   logic [31:0] bus_addr = 32'h0, bus_wdata = 32'h0, bus_rdata, d;
   logic [CHAR_W-1:0] push_byte = 8'h00, tx_data, last_tx, tx_got, rx_push_data, t;
   logic rx_push, rx_full, tx_pop, tx_avail, queue_enable, thr_irq, idle_irq, irq;
   int num_errors = 0;
   int checks = 0;
   logic [7:0] q[$]; // expected receive order
   always #10 ref_clk = ~ref_clk;
   uart_fifo_control #(.DEPTH(16)) i_uart_fifo_control (.ref_clk(ref_clk), .nrst(nrst), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .rx_push(rx_push),
      .rx_push_data(rx_push_data), .rx_full(rx_full), .tx_pop(tx_pop), .tx_data(tx_data), .tx_avail(tx_avail),
      .queue_enable(queue_enable), .rx_threshold_irq(thr_irq), .rx_idle_timeout_irq(idle_irq), .irq(irq));
   line_side_model i_line_side_model (.ref_clk(ref_clk), .nrst(nrst), .push_req(push_req), .push_byte(push_byte),
      .stall(stall), .tx_avail(tx_avail), .tx_data(tx_data), .rx_push(rx_push), .rx_push_data(rx_push_data),
      .tx_pop(tx_pop), .last_tx(last_tx), .tx_got(tx_got));
   // ****************************************************************
   // bus cycles, expectations and the closing report
   // ****************************************************************
   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      bus_wr <= 1'b1;
      bus_addr <= a;
      bus_wdata <= v;
      @(posedge ref_clk);
      bus_wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [31:0] a);
      @(posedge ref_clk);
      bus_rd <= 1'b1;
      bus_addr <= a;
      @(posedge ref_clk);
      bus_rd <= 1'b0;
      #1 d = bus_rdata;
   endtask
   // control bits 5:4 always go out as zero
   task automatic ctl(input logic [7:0] v);
      wr(ADDR_QUEUE_CONTROL, {24'h0, v[7:6], 2'h0, v[3:0]});
   endtask
   task automatic push(input logic [7:0] b);
      @(posedge ref_clk);
      push_req <= 1'b1;
      push_byte <= b;
      @(posedge ref_clk);
      push_req <= 1'b0;
   endtask
   // characters needed per threshold code
   function automatic logic [4:0] exp_chars(input logic [1:0] c);
      case (c)
         2'h0: return 5'h01;
         2'h1: return 5'h04;
         2'h2: return 5'h08;
         default: return 5'h0E;
      endcase
   endfunction
   task automatic complete_run();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      void'($urandom(1));
      repeat (12) @(posedge ref_clk);
      nrst <= 1'b1;
      rd(ADDR_QUEUE_CONTROL);
      `CHK("control", 32'h0, d)
      rd(ADDR_QUEUE_STATUS);
      `CHK("status", 32'h0, d)
      rd(32'h4000_8004);
      `CHK("unmapped", 32'h0, d)
      // every threshold code: irq rises at the count and falls one below
      for (int c = 0; c < 4; c++) begin
         ctl({c[1:0], 6'h03});
         rd(ADDR_QUEUE_STATUS);
         `CHK("thr code", {c[1:0], 1'b1}, d[18:16])
         for (int k = 1; k < exp_chars(c[1:0]); k++) push(8'h5A);
         repeat (3) @(negedge ref_clk);
         `CHK("thr irq low", 1'b0, thr_irq)
         push(8'hA5);
         repeat (3) @(negedge ref_clk);
         `CHK("thr irq", 1'b1, thr_irq)
         rd(ADDR_QUEUE_DATA);
         repeat (3) @(negedge ref_clk);
         `CHK("thr irq drop", 1'b0, thr_irq)
      end
      // disabling empties queues and ignores threshold bits
      ctl(8'h40);
      rd(ADDR_QUEUE_STATUS);
      `CHK("disabled", 19'h60000, d[18:0])
      `CHK("enable", 1'b0, queue_enable)
      push(8'h11);
      ctl(8'h41);
      stall <= 1'b1;
      push(8'h01);
      push(8'h02);
      wr(ADDR_QUEUE_DATA, 32'h33);
      wr(ADDR_QUEUE_DATA, 32'h44);
      ctl(8'h41);
      rd(ADDR_QUEUE_STATUS);
      `CHK("no flush", 19'h30202, d[18:0])
      ctl(8'h43);
      rd(ADDR_QUEUE_STATUS);
      `CHK("rx flush", 19'h30200, d[18:0])
      ctl(8'h45);
      push(8'h03);
      rd(ADDR_QUEUE_STATUS);
      `CHK("tx flush", 19'h30001, d[18:0])
      // overfill by one, then drain in order
      ctl(8'hC3);
      for (int k = 0; k < 17; k++) begin
         t = 8'($urandom);
         if (k < 16) q.push_back(t);
         push(t);
      end
      repeat (3) @(negedge ref_clk);
      `CHK("full", 1'b1, rx_full)
      rd(ADDR_IRQ_STATUS);
      `CHK("overflow", 1'b1, d[IRQ_OVERFLOW_BIT])
      wr(ADDR_IRQ_MASK, 32'h4);
      repeat (2) @(negedge ref_clk);
      `CHK("irq", 1'b1, irq)
      foreach (q[k]) begin
         rd(ADDR_QUEUE_DATA);
         `CHK("rx data", q[k], d[7:0])
      end
      wr(ADDR_IRQ_STATUS, 32'h7);
      repeat (2) @(negedge ref_clk);
      `CHK("irq cleared", 1'b0, irq)
      // idle timeout with a short character time
      wr(ADDR_CHAR_TIME, 32'h2);
      wr(ADDR_IRQ_MASK, 32'h2);
      push(8'h77);
      repeat (2) @(negedge ref_clk);
      `CHK("idle early", 1'b0, idle_irq)
      for (int n = 0; n < 40 && idle_irq !== 1'b1; n++) @(negedge ref_clk);
      if (idle_irq !== 1'b1) begin
         num_errors++;
         complete_run();
      end
      `CHK("idle irq", 1'b1, irq)
      rd(ADDR_QUEUE_DATA);
      repeat (3) @(negedge ref_clk);
      `CHK("idle clear", 1'b0, idle_irq)
      // transmit queue drained by the partner
      for (int k = 0; k < 4; k++) begin
         t = 8'($urandom);
         wr(ADDR_QUEUE_DATA, {24'h0, t});
      end
      stall <= 1'b0;
      for (int n = 0; n < 60 && tx_got !== 8'h04; n++) @(negedge ref_clk);
      if (tx_got !== 8'h04) begin
         num_errors++;
         complete_run();
      end
      `CHK("last tx", t, last_tx)
      complete_run();
   end
endmodule
